// ==== rtl/secs_pkg.sv ====
// Constants, commands and carrier types for the serial EEPROM controller.
// Assumes a 40 MHz system clock; the link runs from a divider of it.
package secs_pkg;
    // Timing
    localparam int CLK_NS        = 25;
    localparam int TMO_MS        = 30;
    localparam int TMO_CYC       = TMO_MS * 1000000 / CLK_NS;
    localparam int LINK_HALF_NS  = 100;
    localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_NS - 1) / CLK_NS;

    // Register offsets (byte addresses)
    localparam logic [11:0] OFS_CMD  = 12'h1b4;
    localparam logic [11:0] OFS_DATA = 12'h1b8;

    // Command/status field positions
    localparam int BIT_BUSY   = 31;
    localparam int CMD_LSB    = 28;
    localparam int BIT_OVF    = 18;
    localparam int BIT_TMO    = 17;
    localparam int BIT_LOADED = 16;

    // Reset values and content constants
    localparam logic [15:0] ADDR_RST    = 16'h0000;
    localparam logic [7:0]  DATA_RST    = 8'h00;
    localparam logic [7:0]  SIGNATURE   = 8'ha5;
    localparam logic [15:0] EEPROM_LAST = 16'h07ff;
    localparam logic [7:0]  I2C_CTRL    = 8'ha0;

    // Link frame lengths
    localparam logic [5:0] NBITS_3W  = 6'd27;
    localparam logic [5:0] NBITS_I2C = 6'd32;

    typedef enum logic [2:0] {
        CMD_READ, CMD_EWDS, CMD_EWEN, CMD_WRITE,
        CMD_WRITE_ALL_CMD, CMD_ERASE, CMD_ERASE_ALL_CMD, CMD_RELOAD
    } secs_cmd_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } secs_reg_req_t;

    typedef struct packed {
        logic        start;
        logic        abort;
        logic        i2c;
        logic [5:0]  nbits;
        logic [2:0]  ack_bytes;
        logic [31:0] frame;
    } secs_link_req_t;

    typedef struct packed {
        logic       busy;
        logic       done;
        logic       ack_err;
        logic       stretch;
        logic       din;
        logic [7:0] rx;
    } secs_link_rsp_t;

    typedef struct packed {
        logic clk_o;
        logic clk_oe;
        logic cs;
        logic dout;
        logic dout_oe;
    } secs_pins_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] index;
        logic [7:0]  data;
    } secs_cfg_t;
endpackage

// ==== rtl/secs_link.sv ====
// Bit engine for the EEPROM link: shifts one frame out MSB first and
// samples the serial input on each rising link clock.
// Assumes the caller keeps req stable in the cycle start is high.
`timescale 1ns/1ps
module secs_link (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               ce,
    // Frame request and answer
    input  secs_pkg::secs_link_req_t req,
    output secs_pkg::secs_link_rsp_t rsp,
    // Pins
    input  wire logic               serial_in,
    input  wire logic               clk_in,
    output secs_pkg::secs_pins_t     pins
);
    import secs_pkg::*;

    localparam logic [2:0] HALF = 3'(LINK_HALF_CYC - 1);

    typedef struct packed {
        logic        busy;
        logic        done;
        logic        ack_err;
        logic        sclk;
        logic        ack_slot;
        logic        i2c;
        logic [2:0]  div;
        logic [5:0]  left;
        logic [2:0]  bitn;
        logic [2:0]  bytes;
        logic [2:0]  ack_bytes;
        logic [31:0] sh;
        logic [7:0]  rx;
        logic [1:0]  din_s;
        logic [1:0]  scl_s;
    } secs_lnk_st_t;

    secs_lnk_st_t q, n;
    logic         dbit;

    always_comb begin
        n = q;
        n.done = 1'b0;
        n.din_s = {q.din_s[0], serial_in};
        n.scl_s = {q.scl_s[0], clk_in};
        if (req.abort) begin
            n.busy = 1'b0;
            n.sclk = 1'b0;
        end else if (!q.busy) begin
            n.i2c = req.i2c;
            if (req.start) begin
                n.busy = 1'b1;
                n.ack_err = 1'b0;
                n.sclk = 1'b0;
                n.div = 3'd0;
                n.left = req.nbits;
                n.bitn = 3'd0;
                n.bytes = 3'd0;
                n.ack_bytes = req.ack_bytes;
                n.sh = req.frame;
                n.ack_slot = 1'b0;
            end
        end else if (q.sclk && q.i2c && !q.scl_s[1]) begin
            // Slave holds the clock low: the phase waits
            n.div = q.div;
        end else if (q.div != HALF) begin
            n.div = q.div + 3'd1;
        end else begin
            n.div = 3'd0;
            n.sclk = !q.sclk;
            if (!q.sclk) begin
                if (q.ack_slot) begin
                    if (q.din_s[1]) begin
                        n.ack_err = 1'b1;
                    end
                end else begin
                    n.rx = {q.rx[6:0], q.din_s[1]};
                end
            end else if (q.ack_slot) begin
                n.ack_slot = 1'b0;
                if (q.left == 6'd0) begin
                    n.busy = 1'b0;
                    n.done = 1'b1;
                end
            end else begin
                n.sh = {q.sh[30:0], 1'b1};
                n.left = q.left - 6'd1;
                n.bitn = q.bitn + 3'd1;
                if (q.i2c && q.bitn == 3'd7 && q.bytes < q.ack_bytes) begin
                    n.ack_slot = 1'b1;
                    n.bytes = q.bytes + 3'd1;
                end else if (q.left == 6'd1) begin
                    n.busy = 1'b0;
                    n.done = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else if (ce) begin
            q <= n;
        end
    end

    // Open-drain lines in I2C mode only ever pull low
    assign dbit         = q.ack_slot ? 1'b1 : q.sh[31];
    assign pins.clk_o   = q.i2c ? 1'b0 : q.sclk;
    assign pins.clk_oe  = q.i2c ? (q.busy & !q.sclk) : 1'b1;
    assign pins.cs      = !q.i2c & q.busy;
    assign pins.dout    = q.i2c ? 1'b0 : dbit;
    assign pins.dout_oe = q.i2c ? (q.busy & !dbit) : 1'b1;

    assign rsp.busy    = q.busy;
    assign rsp.done    = q.done;
    assign rsp.ack_err = q.ack_err;
    assign rsp.stretch = q.busy & q.sclk & q.i2c & !q.scl_s[1];
    assign rsp.din     = q.din_s[1];
    assign rsp.rx      = q.rx;
endmodule

// ==== rtl/secs_top.sv ====
// EEPROM controller: command/status and data registers, command
// sequencing, timeout and the configuration loader.
// Assumes register requests and i2c_mode come from the clk domain.
//
// Functional notes
// - Loader read past last address sets overflow bit18
// - Reload or digital reset clears overflow flag
// - Three-wire program commands time out after 30 ms
// - I2C: missing ack, stretch, unsupported set timeout
// - Writing one clears timeout and loaded flags
// - Three-wire mode pulls serial input low
// - Serial input high: no timeout, busy clears
// - Three-wire: only program commands time out without EEPROM
// - Successful load sets configuration-loaded bit16
// - Loaded flag cleared at resets and reload start
// - 16-bit byte address field, reset zero
// - Data register low byte, upper bits read zero
// - Load fails without A5h signature at location zero
`timescale 1ns/1ps
module secs_top #(
    parameter int unsigned TIMEOUT_CYC = secs_pkg::TMO_CYC
) (
    // Clock, reset and enable
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic              dig_rst,
    // Mode strap
    input  wire logic              i2c_mode,
    // Register access
    input  secs_pkg::secs_reg_req_t reg_req,
    output logic [31:0]            reg_rdata,
    // EEPROM link pins
    output secs_pkg::secs_pins_t    pins,
    input  wire logic              link_clk_in,
    input  wire logic              eeprom_serial_in,
    output logic                   serial_in_pulldown_en,
    // Loaded configuration bytes
    output secs_pkg::secs_cfg_t     cfg
);
    import secs_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_SHIFT, ST_RDY, ST_LD_RD, ST_LD_WAIT
    } secs_state_t;

    typedef struct packed {
        secs_state_t st;
        logic        busy;
        secs_cmd_t   cmd;
        logic [15:0] addr;
        logic [7:0]  data;
        logic        ovf;
        logic        tmo;
        logic        loaded;
        logic [31:0] tcnt;
        logic [1:0]  ld_ph;
        logic [15:0] ld_addr;
        logic [7:0]  ld_left;
        logic        start;
        logic [31:0] rdata;
        secs_cfg_t   cfg;
    } secs_st_t;

    secs_st_t       q, n;
    secs_link_req_t lreq;
    secs_link_rsp_t lrsp;
    logic           go;
    logic           abort;

    function automatic logic is_prog(input secs_cmd_t c);
        return c == CMD_WRITE || c == CMD_WRITE_ALL_CMD ||
               c == CMD_ERASE || c == CMD_ERASE_ALL_CMD;
    endfunction

    function automatic logic [31:0] frame_of(input secs_cmd_t c,
            input logic [15:0] a, input logic [7:0] d, input logic i2c);
        logic [1:0] op;
        logic [1:0] sel;
        logic [7:0] db;
        op  = 2'b00;
        sel = 2'b00;
        db  = (c == CMD_WRITE || c == CMD_WRITE_ALL_CMD) ? d : 8'hff;
        case (c)
            CMD_READ:  op = 2'b10;
            CMD_WRITE: op = 2'b01;
            CMD_ERASE: op = 2'b11;
            CMD_EWEN:  sel = 2'b11;
            CMD_ERASE_ALL_CMD:  sel = 2'b10;
            CMD_WRITE_ALL_CMD:  sel = 2'b01;
            default:   sel = 2'b00;
        endcase
        if (i2c) begin
            return {I2C_CTRL | {7'h00, c == CMD_READ}, a, db};
        end
        if (op == 2'b00) begin
            return {1'b1, op, sel, a[13:0], db, 5'h1f};
        end
        return {1'b1, op, a, db, 5'h1f};
    endfunction

    assign go = reg_req.wr && reg_req.addr == OFS_CMD && !q.busy &&
                reg_req.wdata[BIT_BUSY];

    always_comb begin
        n = q;
        n.start = 1'b0;
        n.cfg.valid = 1'b0;
        abort = 1'b0;
        // Register reads answer one cycle later
        if (reg_req.rd) begin
            if (reg_req.addr == OFS_CMD) begin
                n.rdata = {q.busy, q.cmd, 9'h000, q.ovf, q.tmo,
                           q.loaded, q.addr};
            end else if (reg_req.addr == OFS_DATA) begin
                n.rdata = {24'h000000, q.data};
            end else begin
                n.rdata = 32'h00000000;
            end
        end
        if (reg_req.wr && reg_req.addr == OFS_CMD) begin
            if (reg_req.wdata[BIT_TMO]) begin
                n.tmo = 1'b0;
            end
            if (reg_req.wdata[BIT_LOADED]) begin
                n.loaded = 1'b0;
            end
            if (!q.busy) begin
                n.addr = reg_req.wdata[15:0];
            end
        end
        if (reg_req.wr && reg_req.addr == OFS_DATA && !q.busy) begin
            n.data = reg_req.wdata[7:0];
        end
        // Flag sets below follow the clears so a coincident event wins
        case (q.st)
            ST_IDLE: begin
                if (go) begin
                    n.busy = 1'b1;
                    n.cmd = secs_cmd_t'(reg_req.wdata[CMD_LSB +: 3]);
                    n.tcnt = 32'd0;
                    if (n.cmd == CMD_RELOAD) begin
                        n.loaded = 1'b0;
                        n.ovf = 1'b0;
                        n.ld_ph = 2'd0;
                        n.ld_addr = 16'h0000;
                        n.st = ST_LD_RD;
                    end else if (i2c_mode && n.cmd != CMD_READ &&
                                 n.cmd != CMD_WRITE) begin
                        n.tmo = 1'b1;
                        n.busy = 1'b0;
                    end else begin
                        n.start = 1'b1;
                        n.st = ST_SHIFT;
                    end
                end
            end
            ST_SHIFT, ST_LD_WAIT: begin
                // Only an unbroken clock stretch counts toward the limit
                n.tcnt = 32'd0;
                if (lrsp.stretch) begin
                    n.tcnt = q.tcnt + 32'd1;
                    if (q.tcnt >= TIMEOUT_CYC - 1) begin
                        n.tmo = 1'b1;
                        abort = 1'b1;
                        n.busy = 1'b0;
                        n.st = ST_IDLE;
                    end
                end else if (lrsp.done) begin
                    n.st = ST_IDLE;
                    n.busy = 1'b0;
                    if (i2c_mode && lrsp.ack_err) begin
                        n.tmo = 1'b1;
                    end else if (q.st == ST_SHIFT) begin
                        if (q.cmd == CMD_READ) begin
                            n.data = lrsp.rx;
                        end else if (is_prog(q.cmd) && !i2c_mode) begin
                            n.busy = 1'b1;
                            n.tcnt = 32'd0;
                            n.st = ST_RDY;
                        end
                    end else if (q.ld_ph == 2'd0) begin
                        if (lrsp.rx == SIGNATURE) begin
                            n.busy = 1'b1;
                            n.ld_ph = 2'd1;
                            n.ld_addr = 16'h0001;
                            n.st = ST_LD_RD;
                        end
                    end else if (q.ld_ph == 2'd1) begin
                        n.ld_left = lrsp.rx;
                        n.ld_addr = 16'h0002;
                        if (lrsp.rx == 8'h00) begin
                            n.loaded = 1'b1;
                        end else begin
                            n.busy = 1'b1;
                            n.ld_ph = 2'd2;
                            n.st = ST_LD_RD;
                        end
                    end else begin
                        n.cfg.valid = 1'b1;
                        n.cfg.index = q.ld_addr - 16'h0002;
                        n.cfg.data = lrsp.rx;
                        n.ld_left = q.ld_left - 8'd1;
                        n.ld_addr = q.ld_addr + 16'h0001;
                        if (q.ld_left == 8'd1) begin
                            n.loaded = 1'b1;
                        end else begin
                            n.busy = 1'b1;
                            n.st = ST_LD_RD;
                        end
                    end
                end
            end
            ST_RDY: begin
                // A high serial input means the part is ready
                if (lrsp.din) begin
                    n.busy = 1'b0;
                    n.st = ST_IDLE;
                end else begin
                    n.tcnt = q.tcnt + 32'd1;
                    if (q.tcnt >= TIMEOUT_CYC - 1) begin
                        n.tmo = 1'b1;
                        n.busy = 1'b0;
                        n.st = ST_IDLE;
                    end
                end
            end
            ST_LD_RD: begin
                if (q.ld_ph == 2'd2 && q.ld_addr > EEPROM_LAST) begin
                    n.ovf = 1'b1;
                    n.busy = 1'b0;
                    n.st = ST_IDLE;
                end else begin
                    n.start = 1'b1;
                    n.tcnt = 32'd0;
                    n.st = ST_LD_WAIT;
                end
            end
            default: n.st = ST_IDLE;
        endcase
        if (dig_rst) begin
            n = '0;
            abort = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.addr <= ADDR_RST;
            q.data <= DATA_RST;
        end else if (ce) begin
            q <= n;
        end
    end

    // Loader always reads; the frame is taken in the start cycle
    always_comb begin
        lreq.start = q.start;
        lreq.abort = abort;
        lreq.i2c = i2c_mode;
        lreq.nbits = i2c_mode ? NBITS_I2C : NBITS_3W;
        if (q.st == ST_SHIFT) begin
            lreq.frame = frame_of(q.cmd, q.addr, q.data, i2c_mode);
            lreq.ack_bytes = (q.cmd == CMD_READ) ? 3'd3 : 3'd4;
        end else begin
            lreq.frame = frame_of(CMD_READ, q.ld_addr, 8'hff, i2c_mode);
            lreq.ack_bytes = 3'd3;
        end
    end

    secs_link u_link (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .req       (lreq),
        .rsp       (lrsp),
        .serial_in (eeprom_serial_in),
        .clk_in    (link_clk_in),
        .pins      (pins)
    );

    assign serial_in_pulldown_en = !i2c_mode;
    assign reg_rdata = q.rdata;
    assign cfg = q.cfg;
endmodule

// ==== bench/secs_props.sv ====
// Concurrent checks on the EEPROM controller top-level ports.
// Assumes a single clk domain with rst as the only disable.
`timescale 1ns/1ps
module secs_props #(
    parameter int unsigned TIMEOUT_CYC = secs_pkg::TMO_CYC
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               ce,
    input  wire logic               dig_rst,
    // Mode and registers
    input  wire logic               i2c_mode,
    input  secs_pkg::secs_reg_req_t reg_req,
    input  wire logic [31:0]        reg_rdata,
    // Link and loader
    input  secs_pkg::secs_pins_t    pins,
    input  wire logic               link_clk_in,
    input  wire logic               eeprom_serial_in,
    input  wire logic               serial_in_pulldown_en,
    input  secs_pkg::secs_cfg_t     cfg
);
    import secs_pkg::*;
    logic wr_cmd;
    logic rd_cmd;
    assign wr_cmd = ce && reg_req.wr && reg_req.addr == OFS_CMD;
    assign rd_cmd = ce && reg_req.rd && reg_req.addr == OFS_CMD;
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_pulldown;
        serial_in_pulldown_en == !i2c_mode;
    endproperty
    a_pulldown: assert property (p_pulldown)
        else $error("pull-down enable wrong for mode");

    property p_unmapped;
        ce && reg_req.rd && reg_req.addr != OFS_CMD
            && reg_req.addr != OFS_DATA |=> reg_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_data_hi;
        ce && reg_req.rd && reg_req.addr == OFS_DATA
            |=> reg_rdata[31:8] == 24'h0;
    endproperty
    a_data_hi: assert property (p_data_hi)
        else $error("data register upper bits not zero");

    property p_tmo_w1c;
        wr_cmd && reg_req.wdata[17] && !reg_req.wdata[31]
            ##1 !reg_req.wr ##1 rd_cmd |=> !reg_rdata[17];
    endproperty
    a_tmo_w1c: assert property (p_tmo_w1c)
        else $error("timeout flag not cleared by write one");

    property p_loaded_w1c;
        wr_cmd && reg_req.wdata[16] && !reg_req.wdata[31]
            ##1 !reg_req.wr ##1 rd_cmd |=> !reg_rdata[16];
    endproperty
    a_loaded_w1c: assert property (p_loaded_w1c)
        else $error("loaded flag not cleared by write one");

    // Three-wire frames last far longer than two cycles
    property p_busy;
        wr_cmd && reg_req.wdata[31] && !i2c_mode ##1 !reg_req.wr
            ##1 rd_cmd |=> reg_rdata[31];
    endproperty
    a_busy: assert property (p_busy)
        else $error("busy not shown after command");

    property p_dig;
        ce && dig_rst ##1 !reg_req.wr ##1 rd_cmd
            |=> reg_rdata[18:16] == 3'b000 && !reg_rdata[31];
    endproperty
    a_dig: assert property (p_dig)
        else $error("flags survive digital reset");

    property p_cfg;
        cfg.valid |=> !cfg.valid;
    endproperty
    a_cfg: assert property (p_cfg)
        else $error("config byte strobe longer than one cycle");
endmodule

// ==== bench/secs_eeprom.sv ====
// Behavioural three-wire serial EEPROM for the controller bench.
// Assumes MSB-first frames and sampling on the rising link clock.
`timescale 1ns/1ps
module secs_eeprom (
    // Link pins
    input  wire logic sclk,
    input  wire logic cs,
    input  wire logic di,
    // Bench control
    input  wire logic present,
    output logic      so
);
    logic [7:0]  mem [0:2047];
    logic [26:0] sh;
    logic [15:0] ad;
    logic [7:0]  rb;
    logic [1:0]  op;
    logic        drv;
    int          cnt;
    int          busy_ns;
    initial begin
        drv = 1'b0;
        cnt = 0;
        busy_ns = 2000;
    end
    // Without a part the pad pull-down wins
    assign so = present ? drv : 1'b0;
    always @(posedge cs) cnt = 0;
    always @(posedge sclk) if (cs) begin
        sh = {sh[25:0], di};
        cnt = cnt + 1;
    end
    // Idle bits toggle mid-frame; the tail is low so the ready wait
    // after a program frame always starts from busy
    always @(negedge sclk) if (cs) begin
        if (cnt == 19) begin
            op = sh[17:16];
            ad = sh[15:0];
            rb = mem[sh[10:0]];
        end
        if (cnt >= 19 && cnt <= 26 && op == 2'b10)
            drv = rb[26 - cnt];
        else if (cnt < 26)
            drv = ~drv;
        else
            drv = 1'b0;
    end
    always @(negedge cs) if (present && cnt == 27) begin
        case (op)
            2'b01: mem[ad[10:0]] = sh[7:0];
            2'b11: mem[ad[10:0]] = 8'hff;
            2'b00: if (ad[15] != ad[14])
                for (int i = 0; i < 2048; i++)
                    mem[i] = ad[14] ? sh[7:0] : 8'hff;
            default: ;
        endcase
        drv = 1'b0;
        if (op == 2'b01 || op == 2'b11 || (op == 2'b00 && ad[15] != ad[14]))
            drv <= #(busy_ns) 1'b1;
    end
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench for the EEPROM controller registers and link.
// Assumes a three-wire EEPROM model; I2C lines are pulled up.
`timescale 1ns/1ps
module tb_top;
    import secs_pkg::*;
    localparam int TIMEOUT_CYC = 200;
    logic          clk, rst, ce, dig_rst, i2c_mode, present;
    logic          link_clk_in, sdi, pd_en, ee_so, hold_scl;
    logic [31:0]   rdata, rv;
    logic [15:0]   rnd, a;
    logic [7:0]    d;
    logic [7:0]    cfg_seen [0:7];
    logic [7:0]    exp_b [0:2];
    int            fails, checks_done, ncfg;
    secs_reg_req_t req;
    secs_pins_t    pins;
    secs_cfg_t     cfg;

    // Open-drain lines read high unless a party pulls them low
    assign sdi = i2c_mode ? ~pins.dout_oe : ee_so;
    // hold_scl plays a slave that keeps the clock line low
    assign link_clk_in = i2c_mode ? ~pins.clk_oe & ~hold_scl : pins.clk_o;

    secs_top #(.TIMEOUT_CYC(TIMEOUT_CYC)) dut_u (
        .clk(clk), .rst(rst), .ce(ce), .dig_rst(dig_rst),
        .i2c_mode(i2c_mode), .reg_req(req), .reg_rdata(rdata),
        .pins(pins), .link_clk_in(link_clk_in), .eeprom_serial_in(sdi),
        .serial_in_pulldown_en(pd_en), .cfg(cfg));
    secs_eeprom ee_u (.sclk(pins.clk_o), .cs(pins.cs), .di(pins.dout),
        .present(present), .so(ee_so));

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic prog_cmd(input int k);
        return k >= 3 && k <= 6;
    endfunction

    task automatic chk(input string nm, input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] ad, input logic [31:0] dt);
        @(negedge clk);
        req.wr = 1'b1;
        req.addr = ad;
        req.wdata = dt;
        @(negedge clk);
        req.wr = 1'b0;
    endtask
    task automatic rd(input logic [11:0] ad, output logic [31:0] dt);
        @(negedge clk);
        req.rd = 1'b1;
        req.addr = ad;
        @(negedge clk);
        req.rd = 1'b0;
        dt = rdata;
    endtask
    task automatic cmd(input secs_cmd_t c, input logic [15:0] ad);
        wr(OFS_CMD, {1'b1, c, 12'h000, ad});
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        rd(OFS_CMD, rv);
        while (rv[31] !== 1'b0 && n < 3000) begin
            rd(OFS_CMD, rv);
            n++;
        end
        chk("busy", rv[31], 1'b0);
    endtask
    task automatic clr(input int b);
        wr(OFS_CMD, 32'h1 << b);
        rd(OFS_CMD, rv);
        chk("w1c", rv[b], 1'b0);
    endtask
    task automatic load(input logic [7:0] sig);
        ee_u.mem[0] = sig;
        ee_u.mem[1] = 8'h03;
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            exp_b[i] = rnd[7:0];
            ee_u.mem[2 + i] = rnd[7:0];
        end
        ncfg = 0;
        cmd(CMD_RELOAD, 16'h0000);
        wait_idle();
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk) if (cfg.valid === 1'b1) begin
        cfg_seen[cfg.index[2:0]] <= cfg.data;
        ncfg <= ncfg + 1;
    end

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #(25 * 40000);
        fails++;
        report_and_stop();
    end
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        dig_rst = 1'b0;
        i2c_mode = 1'b0;
        present = 1'b1;
        hold_scl = 1'b0;
        req = '0;
        rnd = 16'h0008;
        fails = 0;
        checks_done = 0;
        ncfg = 0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        rd(OFS_CMD, rv);
        chk("cmd reset", rv, 32'h0);
        rd(OFS_DATA, rv);
        chk("data reset", rv, 32'h0);
        rd(12'h1bc, rv);
        chk("unmapped", rv, 32'h0);
        chk("pulldown", pd_en, 1'b1);
        wr(OFS_DATA, 32'hffff_ff5a);
        rd(OFS_DATA, rv);
        chk("data byte", rv, 32'h5a);
        wr(OFS_CMD, 32'h0000_beef);
        rd(OFS_CMD, rv);
        chk("addr field", rv, 32'hbeef);
        $display("TEST registers done");
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            a = (i == 0) ? 16'h07ff : {5'h00, rnd[10:0]};
            d = rnd[15:8];
            ee_u.busy_ns = (i == 1) ? 40 : 4000;
            wr(OFS_DATA, {24'h0, d});
            cmd(CMD_WRITE, a);
            // A new command and a data write land while busy: dropped
            cmd(CMD_ERASE, ~a);
            wr(OFS_DATA, 32'h0);
            wait_idle();
            chk("cmd kept", rv, {1'b0, CMD_WRITE, 12'h000, a});
            chk("stored", ee_u.mem[a[10:0]], d);
            wr(OFS_DATA, 32'h0);
            cmd(CMD_READ, a);
            wait_idle();
            rd(OFS_DATA, rv);
            chk("read back", rv, {24'h0, d});
        end
        $display("TEST write read done");
        present = 1'b0;
        for (int k = 0; k < 7; k++) begin
            cmd(secs_cmd_t'(k), 16'h0010);
            wait_idle();
            chk("timeout", rv[17], prog_cmd(k));
            wr(OFS_CMD, 32'h0);
            rd(OFS_CMD, rv);
            chk("w0 keeps", rv[17], prog_cmd(k));
            clr(17);
        end
        $display("TEST timeout done");
        present = 1'b1;
        load(8'ha5);
        chk("loaded", rv[18:16], 3'b001);
        chk("cfg count", ncfg, 3);
        for (int i = 0; i < 3; i++)
            chk("cfg byte", cfg_seen[i], exp_b[i]);
        load(8'h5a);
        chk("bad sig", rv[16], 1'b0);
        chk("no cfg", ncfg, 0);
        load(8'ha5);
        clr(16);
        load(8'ha5);
        @(negedge clk);
        dig_rst = 1'b1;
        @(negedge clk);
        dig_rst = 1'b0;
        rd(OFS_CMD, rv);
        chk("dig reset", rv, 32'h0);
        $display("TEST loader done");
        @(negedge clk);
        i2c_mode = 1'b1;
        repeat (3) @(negedge clk);
        chk("pulldown off", pd_en, 1'b0);
        cmd(CMD_EWEN, 16'h0000);
        rd(OFS_CMD, rv);
        chk("unsupported", {rv[31], rv[17]}, 2'b01);
        clr(17);
        cmd(CMD_READ, 16'h0040);
        wait_idle();
        chk("no ack", rv[17], 1'b1);
        clr(17);
        hold_scl = 1'b1;
        cmd(CMD_READ, 16'h0040);
        wait_idle();
        chk("stretch", rv[17], 1'b1);
        hold_scl = 1'b0;
        $display("TEST i2c done");
        report_and_stop();
    end
endmodule

bind secs_top secs_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) props_u (
    .clk(clk), .rst(rst), .ce(ce), .dig_rst(dig_rst),
    .i2c_mode(i2c_mode), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .pins(pins), .link_clk_in(link_clk_in),
    .eeprom_serial_in(eeprom_serial_in),
    .serial_in_pulldown_en(serial_in_pulldown_en), .cfg(cfg));
